// ===== logic/ftm_ctrl.sv
// remote command/mode register and firmware transaction key register
// assumes a master that keeps strobes one cycle and never both at once
`timescale 1ns/10ps
// Function
// - bit 20 starts data recall if unlocked
// - bit 19 starts code recall if unlocked
// - bit 18 starts user image erase if unlocked
// - bit 17 starts store and lock
// - bit 16 starts store without lock
// - transactions only while key holds unlock code
// - key write-only, resets locked, flag in status
// - data1 read protect field, 01 reset
// - bandgap field, 01 reset
// - fast oscillator field, 01 reset
// - debug enable field, 01 reset
// - uart crc mode field, 01 reset
// - fast clock select field, 10 reset
// - configuration ok field, 01 reset
// - command bits clear themselves, read zero
module ftm_ctrl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic data_recall_cmd_out,
  output logic code_recall_cmd_out,
  output logic user_image_erase_cmd_out,
  output logic image_store_and_lock_cmd_out,
  output logic image_store_cmd_out,
  output logic [1:0] data1_read_protect_mode_out,
  output logic [1:0] bandgap_mode_out,
  output logic [1:0] fast_oscillator_mode_out,
  output logic [1:0] debug_enable_field_out,
  output logic [1:0] uart_crc_mode_out,
  output logic [1:0] fast_clock_select_out,
  output logic [1:0] config_ok_out,
  output logic transaction_unlock_flag_out
);
  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic wr_cmd;
  logic wr_key;
  logic [31:0] key_r;
  logic unlocked;
  logic [ftm_pkg::NUM_CMDS-1:0] cmd_r;
  logic [ftm_pkg::NUM_CMDS-1:0] cmd_nxt;
  logic [1:0] field_st [ftm_pkg::NUM_FIELDS];
  logic [31:0] rdata_nxt;

  assign wr_cmd = wr_in && (addr_in == ftm_pkg::CMD_MODE_IDX);
  assign wr_key = wr_in && (addr_in == ftm_pkg::TRANS_KEY_IDX);
  assign unlocked = (key_r == ftm_pkg::UNLOCK_CODE);

  // -------------------------------------------------------------
  // transaction key
  // -------------------------------------------------------------
  // any value may be written; only the exact code unlocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_r <= ftm_pkg::KEY_RST;
    end else if (wr_key) begin
      key_r <= wdata_in;
    end
  end
  assign transaction_unlock_flag_out = unlocked;

  // -------------------------------------------------------------
  // command pulses
  // -------------------------------------------------------------
  // commands gated by the key; a bit clears one cycle after its write unless written again
  always_comb begin
    cmd_nxt = '0;
    if (wr_cmd && unlocked) begin
      cmd_nxt = wdata_in[ftm_pkg::DATA_RECALL_BIT:ftm_pkg::STORE_BIT];
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end
  assign data_recall_cmd_out = cmd_r[4];
  assign code_recall_cmd_out = cmd_r[3];
  assign user_image_erase_cmd_out = cmd_r[2];
  assign image_store_and_lock_cmd_out = cmd_r[1];
  assign image_store_cmd_out = cmd_r[0];

  // -------------------------------------------------------------
  // radio button fields
  // -------------------------------------------------------------
  localparam int LSB_TAB [ftm_pkg::NUM_FIELDS] = '{
    ftm_pkg::CFG_OK_LSB, ftm_pkg::FAST_CLK_LSB, ftm_pkg::CRC_LSB,
    ftm_pkg::DEBUG_LSB, ftm_pkg::FAST_OSC_LSB, ftm_pkg::BANDGAP_LSB};
  localparam logic [1:0] RST_TAB [ftm_pkg::NUM_FIELDS] = '{
    ftm_pkg::CFG_OK_RST, ftm_pkg::FAST_CLK_RST, ftm_pkg::CRC_RST,
    ftm_pkg::DEBUG_RST, ftm_pkg::FAST_OSC_RST, ftm_pkg::BANDGAP_RST};

  // the data1 field sits above the others
  logic [1:0] data1_st;
  ftm_radio_field #(.RST_VAL(ftm_pkg::DATA1_RST)) u_data1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_cmd),
    .code_in(wdata_in[ftm_pkg::DATA1_LSB +: 2]),
    .state_out(data1_st)
  );

  for (genvar g = 0; g < ftm_pkg::NUM_FIELDS; g++) begin : g_field
    if (g < ftm_pkg::NUM_FIELDS - 1) begin : g_inst
      ftm_radio_field #(.RST_VAL(RST_TAB[g])) u_fld (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_cmd),
        .code_in(wdata_in[LSB_TAB[g] +: 2]),
        .state_out(field_st[g])
      );
    end else begin : g_bg
      ftm_radio_field #(.RST_VAL(RST_TAB[g])) u_fld (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_cmd),
        .code_in(wdata_in[LSB_TAB[g] +: 2]),
        .state_out(field_st[g])
      );
    end
  end

  assign data1_read_protect_mode_out = data1_st;
  assign bandgap_mode_out = field_st[5];
  assign fast_oscillator_mode_out = field_st[4];
  assign debug_enable_field_out = field_st[3];
  assign uart_crc_mode_out = field_st[2];
  assign fast_clock_select_out = field_st[1];
  assign config_ok_out = field_st[0];

  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  // key reads zero so the code cannot be sniffed back
  always_comb begin
    rdata_nxt = '0;
    unique case (addr_in)
      ftm_pkg::CMD_MODE_IDX: begin
        rdata_nxt[ftm_pkg::DATA1_LSB +: 2] = data1_st;
        for (int i = 0; i < ftm_pkg::NUM_FIELDS; i++) begin
          rdata_nxt[LSB_TAB[i] +: 2] = field_st[i];
        end
      end
      ftm_pkg::MISC_STATUS_IDX: begin
        rdata_nxt[ftm_pkg::UNLOCK_FLAG_BIT] = unlocked;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= '0;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_cmd_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::ERASE_BIT] && unlocked
      |=> user_image_erase_cmd_out;
  endproperty
  a_cmd_gate: assert property (p_cmd_gate)
    else $error("erase command not pulsed");
  property p_locked;
    @(posedge clk_in) disable iff (!rst_n_in)
    !unlocked |=> cmd_r == '0;
  endproperty
  a_locked: assert property (p_locked)
    else $error("command ran while locked");
  property p_recall;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && unlocked && wdata_in[ftm_pkg::DATA_RECALL_BIT]
      |=> data_recall_cmd_out;
  endproperty
  a_recall: assert property (p_recall)
    else $error("data recall missed");
  property p_store;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && unlocked && wdata_in[ftm_pkg::STORE_BIT] |=> image_store_cmd_out;
  endproperty
  a_store: assert property (p_store)
    else $error("store missed");
  property p_key;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_key |=> transaction_unlock_flag_out ==
               (ftm_pkg::UNLOCK_CODE == $past(wdata_in));
  endproperty
  a_key: assert property (p_key)
    else $error("unlock flag wrong after key write");
  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && (wdata_in[3:2] == 2'h0 || wdata_in[3:2] == 2'h3)
      |=> $stable(fast_clock_select_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock select changed on no-change code");
  property p_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[13:12] == ftm_pkg::CODE_B
      |=> data1_read_protect_mode_out == ftm_pkg::CODE_B;
  endproperty
  a_set: assert property (p_set)
    else $error("data1 field not set");
  property p_rd;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == ftm_pkg::TRANS_KEY_IDX |=> rdata_out == '0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("key register readable");
  // back to back commands are legal, so clearing is checked on its own
  property p_self_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    !(wr_cmd && unlocked) |=> cmd_r == '0;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("command bit did not clear");
  property p_code_recall;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && unlocked && wdata_in[ftm_pkg::CODE_RECALL_BIT]
      |=> code_recall_cmd_out;
  endproperty
  a_code_recall: assert property (p_code_recall)
    else $error("code recall missed");
  property p_store_lock;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && unlocked && wdata_in[ftm_pkg::STORE_LOCK_BIT]
      |=> image_store_and_lock_cmd_out;
  endproperty
  a_store_lock: assert property (p_store_lock)
    else $error("store and lock missed");
  // fields take an active code on the edge after the write; the debug field is checked holding on code 11
  property p_bandgap;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::BANDGAP_LSB +: 2] == ftm_pkg::CODE_B
      |=> bandgap_mode_out == ftm_pkg::CODE_B;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap field not set");
  property p_fast_osc;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::FAST_OSC_LSB +: 2] == ftm_pkg::CODE_A
      |=> fast_oscillator_mode_out == ftm_pkg::CODE_A;
  endproperty
  a_fast_osc: assert property (p_fast_osc)
    else $error("fast oscillator field not set");
  property p_debug;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::DEBUG_LSB +: 2] == 2'h3
      |=> $stable(debug_enable_field_out);
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug field changed on no-change code");
  property p_crc;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::CRC_LSB +: 2] == ftm_pkg::CODE_A
      |=> uart_crc_mode_out == ftm_pkg::CODE_A;
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc mode field not set");
  property p_clk_sel;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::FAST_CLK_LSB +: 2] == ftm_pkg::CODE_A
      |=> fast_clock_select_out == ftm_pkg::CODE_A;
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("clock select field not set");
  property p_cfg_ok;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_cmd && wdata_in[ftm_pkg::CFG_OK_LSB +: 2] == ftm_pkg::CODE_B
      |=> config_ok_out == ftm_pkg::CODE_B;
  endproperty
  a_cfg_ok: assert property (p_cfg_ok)
    else $error("configuration field not set");
  // a read of the mode register never shows a pending command
  property p_mode_rd;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == ftm_pkg::CMD_MODE_IDX
      |=> rdata_out[ftm_pkg::DATA_RECALL_BIT:ftm_pkg::STORE_BIT] == '0 &&
          rdata_out[ftm_pkg::DATA1_LSB +: 2] ==
          $past(data1_read_protect_mode_out);
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode read shows command or wrong field");
  c_unlock: cover property (@(posedge clk_in) wr_key && unlocked);
  c_erase: cover property (@(posedge clk_in) user_image_erase_cmd_out);
  c_cfg: cover property (@(posedge clk_in) config_ok_out == ftm_pkg::CODE_B);
  c_locked: cover property (@(posedge clk_in) wr_cmd && !unlocked);
endmodule : ftm_ctrl

// ===== pkg/ftm_pkg.sv
// package for the firmware transaction and mode control register bank
// assumes a plain address/strobe register port with 8-bit word indexes
package ftm_pkg;
  // -------------------------------------------------------------
  // register indexes and bus widths
  // -------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CMD_MODE_IDX = 8'hde;
  localparam logic [7:0] TRANS_KEY_IDX = 8'hdf;
  localparam logic [7:0] MISC_STATUS_IDX = 8'he0; // unlock flag lives here
  // -------------------------------------------------------------
  // command bit positions
  // -------------------------------------------------------------
  localparam int DATA_RECALL_BIT = 20;
  localparam int CODE_RECALL_BIT = 19;
  localparam int ERASE_BIT = 18;
  localparam int STORE_LOCK_BIT = 17;
  localparam int STORE_BIT = 16;
  localparam int NUM_CMDS = 5;
  // -------------------------------------------------------------
  // option fields: lsb positions and reset values
  // -------------------------------------------------------------
  localparam int NUM_FIELDS = 6;
  localparam int DATA1_LSB = 12;
  localparam int BANDGAP_LSB = 10;
  localparam int FAST_OSC_LSB = 8;
  localparam int DEBUG_LSB = 6;
  localparam int CRC_LSB = 4;
  localparam int FAST_CLK_LSB = 2;
  localparam int CFG_OK_LSB = 0;
  localparam logic [1:0] CODE_A = 2'h1; // first active code
  localparam logic [1:0] CODE_B = 2'h2; // second active code
  localparam logic [1:0] DATA1_RST = 2'h1;
  localparam logic [1:0] BANDGAP_RST = 2'h1;
  localparam logic [1:0] FAST_OSC_RST = 2'h1;
  localparam logic [1:0] DEBUG_RST = 2'h1;
  localparam logic [1:0] CRC_RST = 2'h1;
  localparam logic [1:0] FAST_CLK_RST = 2'h2;
  localparam logic [1:0] CFG_OK_RST = 2'h1;
  // -------------------------------------------------------------
  // transaction key codes
  // -------------------------------------------------------------
  localparam logic [31:0] UNLOCK_CODE = 32'h50f5_b8ca;
  localparam logic [31:0] KEY_RST = 32'haf0a_7435;
  localparam int UNLOCK_FLAG_BIT = 0;
endpackage : ftm_pkg

// ===== logic/ftm_radio_field.sv
// one two-bit radio button field: only codes 01 and 10 change it
// assumes write strobe and data synchronous to clk_in
`timescale 1ns/10ps
module ftm_radio_field #(
  parameter logic [1:0] RST_VAL = 2'h1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [1:0] code_in,
  output logic [1:0] state_out
);
  // -------------------------------------------------------------
  // state update
  // -------------------------------------------------------------
  // no-change codes let software skip a read before writing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_out <= RST_VAL;
    end else if (wr_in && (code_in == ftm_pkg::CODE_A ||
                           code_in == ftm_pkg::CODE_B)) begin
      state_out <= code_in;
    end
  end
endmodule : ftm_radio_field

// ===== verification/testbench.sv
// self-checking bench for the command/mode and transaction key registers
// assumes ftm_ctrl with its own assertions and a 100 MHz clock
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // clock, reset and bus drivers
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_out;
  wire logic [4:0] cmds;
  wire logic [13:0] flds;
  logic unlock;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] got;
  always #5 clk_in = ~clk_in;
  ftm_ctrl ftm_ctrl_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
    .data_recall_cmd_out(cmds[4]), .code_recall_cmd_out(cmds[3]),
    .user_image_erase_cmd_out(cmds[2]),
    .image_store_and_lock_cmd_out(cmds[1]), .image_store_cmd_out(cmds[0]),
    .data1_read_protect_mode_out(flds[13:12]),
    .bandgap_mode_out(flds[11:10]), .fast_oscillator_mode_out(flds[9:8]),
    .debug_enable_field_out(flds[7:6]), .uart_crc_mode_out(flds[5:4]),
    .fast_clock_select_out(flds[3:2]), .config_ok_out(flds[1:0]),
    .transaction_unlock_flag_out(unlock)
  );
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // write strobe one cycle; returns just after the taking edge settles
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask : bus_wr
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata_out;
  endtask : bus_rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    chk("fields", 32'h1559, {18'h0, flds});
    chk("cmds", 32'h0, {27'h0, cmds});
    chk("flag", 32'h0, {31'h0, unlock});
    bus_rd(ftm_pkg::CMD_MODE_IDX, got);
    chk("mode read", 32'h1559, got);
    bus_rd(ftm_pkg::TRANS_KEY_IDX, got);
    chk("key read", 32'h0, got);
    bus_rd(8'h10, got);
    chk("unmapped read", 32'h0, got);
    $display("test_reset done");
  endtask : test_reset
  // locked: every command is dropped and reads back zero
  task automatic test_locked;
    for (int i = 0; i < 5; i++) begin
      bus_wr(ftm_pkg::CMD_MODE_IDX, 32'h1 << (16 + i));
      chk("locked cmd", 32'h0, {27'h0, cmds});
    end
    bus_rd(ftm_pkg::CMD_MODE_IDX, got);
    chk("cmd readback", 32'h1559, got);
    $display("test_locked done");
  endtask : test_locked
  // unlocked: each command pulses alone for one cycle
  task automatic test_commands;
    bus_wr(ftm_pkg::TRANS_KEY_IDX, ftm_pkg::UNLOCK_CODE);
    chk("flag set", 32'h1, {31'h0, unlock});
    bus_rd(ftm_pkg::MISC_STATUS_IDX, got);
    chk("status", 32'h1, got & 32'h1);
    for (int i = 0; i < 5; i++) begin
      bus_wr(ftm_pkg::CMD_MODE_IDX, 32'h1 << (16 + i));
      chk("cmd pulse", 32'h1 << i, {27'h0, cmds});
      @(posedge clk_in);
      #1;
      chk("cmd clear", 32'h0, {27'h0, cmds});
    end
    chk("fields kept", 32'h1559, {18'h0, flds});
    // a wrong key value locks again
    bus_wr(ftm_pkg::TRANS_KEY_IDX, ftm_pkg::UNLOCK_CODE ^ 32'h1);
    chk("flag clear", 32'h0, {31'h0, unlock});
    bus_wr(ftm_pkg::CMD_MODE_IDX, 32'h0004_0000);
    chk("relocked cmd", 32'h0, {27'h0, cmds});
    $display("test_commands done");
  endtask : test_commands
  // radio fields: 01/10 take, 00/11 hold, one field alone
  task automatic test_fields;
    logic [31:0] wv [6] = '{32'h2aaa, 32'h0, 32'h3fff, 32'h4,
                            32'h1555, 32'h2};
    logic [31:0] ev [6] = '{32'h2aaa, 32'h2aaa, 32'h2aaa, 32'h2aa6,
                            32'h1555, 32'h1556};
    for (int i = 0; i < 6; i++) begin
      bus_wr(ftm_pkg::CMD_MODE_IDX, wv[i]);
      chk("fields", ev[i], {18'h0, flds});
    end
    // one field alone, the rest given the no-change code
    bus_wr(ftm_pkg::CMD_MODE_IDX, 32'h8);
    chk("clk 8 MHz", 32'h155a, {18'h0, flds});
    bus_wr(ftm_pkg::CMD_MODE_IDX, 32'h4);
    chk("clk 4 MHz", 32'h1556, {18'h0, flds});
    bus_rd(ftm_pkg::CMD_MODE_IDX, got);
    chk("field read", 32'h1556, got);
    $display("test_fields done");
  endtask : test_fields
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    test_reset();
    test_locked();
    test_commands();
    test_fields();
    give_verdict();
  end
endmodule : testbench
